/* File: src/pin_boot_strap.sv */
`timescale 1ns/1ps
`include "pin_ctl_params.svh"
module pin_boot_strap
  import pin_ctl_pkg::*;
#(
  parameter bit HAS_BOOT_ROM = 1'b1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Strap level and flag value
  input  wire logic strap_lvl,
  input  wire logic flag_level,
  // Results
  output logic      boot_en,
  output logic      boot_rom_sel,
  output logic      flag_out,
  output logic      flag_oe
);

  boot_state_t state_ff;
  boot_state_t nxt_state;
  logic [2:0]  cnt_ff;
  logic [2:0]  nxt_cnt;
  logic        boot_en_ff;
  logic        nxt_boot_en;
  logic        sel_ff;
  logic        nxt_sel;
  logic        flag_ff;
  logic        nxt_flag;
  logic        oe_ff;
  logic        nxt_oe;

  // The strap is read through the synchroniser, so the pin is held as an
  // input until the synchroniser has filled with the pin's real level.
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_boot_en = boot_en_ff;
    nxt_sel     = sel_ff;
    nxt_flag    = flag_ff;
    nxt_oe      = oe_ff;
    case (state_ff)
      BOOT_SAMPLE:
      begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == `BOOT_WAIT)
        begin
          nxt_boot_en = strap_lvl;
          nxt_sel     = HAS_BOOT_ROM & strap_lvl;
          nxt_state   = BOOT_RUN;
          nxt_flag    = 1'b1;
          nxt_oe      = 1'b1;
        end
      end
      BOOT_RUN:
      begin
        nxt_flag = flag_level;
        nxt_oe = 1'b1;
      end
      default:
      begin
        nxt_state = BOOT_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_ff   <= BOOT_SAMPLE;
      cnt_ff     <= 3'h0;
      boot_en_ff <= 1'b0;
      sel_ff     <= 1'b0;
      flag_ff    <= 1'b0;
      oe_ff      <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      boot_en_ff <= nxt_boot_en;
      sel_ff     <= nxt_sel;
      flag_ff    <= nxt_flag;
      oe_ff      <= nxt_oe;
    end
  end

  assign boot_en      = boot_en_ff;
  assign boot_rom_sel = sel_ff;
  assign flag_out     = flag_ff;
  assign flag_oe      = oe_ff;

  AST_BOOT_CAPTURE: assert property (@(posedge mclk) disable iff (reset)
    $rose(oe_ff) |-> boot_en_ff == $past(strap_lvl))
    else $error("Strap value not captured at the end of sampling.");

  AST_FLAG_HIGH: assert property (@(posedge mclk) disable iff (reset)
    $rose(oe_ff) |-> flag_ff)
    else $error("Flag output not high when first driven.");

  AST_NO_ROM_BOOT: assert property (@(posedge mclk) disable iff (reset)
    sel_ff |-> (HAS_BOOT_ROM && boot_en_ff))
    else $error("Boot select active on a part without boot memory.");

endmodule : pin_boot_strap

/* File: src/pin_ctl_params.svh */
`ifndef PIN_CTL_PARAMS_SVH
`define PIN_CTL_PARAMS_SVH

// Register byte offsets.
`define ADDR_SYSCTL    8'h00
`define ADDR_SYSCTL2   8'h04
`define ADDR_IRQ_CFG   8'h08
`define ADDR_GPIO_DIR  8'h0c
`define ADDR_GPIO_OUT  8'h10
`define ADDR_GPIO_IN   8'h14
`define ADDR_IRQ_STAT  8'h18
`define ADDR_IRQ_MASK  8'h1c

// Field positions.
`define CLK_SEL_BIT    14
`define CLK_EN_BIT     0
`define BOOT_EN_BIT    3
`define FLAG_BIT       0

// Reset values.
`define RST_CLK_SEL    1'b0
`define RST_CLK_EN     1'b1
`define RST_FLAG       1'b1
`define RST_SYNC       1'b1

// Widths, indices, timing counts and response codes.
`define GPIO_N         4
`define PWM_W          8
`define SYNC_N         8
`define SY_IRQA        0
`define SY_IRQB        1
`define SY_FLTA        2
`define SY_FLTB        3
`define SY_EMU         4
`define SY_BOOT        5
`define SY_E0          6
`define SY_F6          7
`define BOOT_WAIT      3'h5
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

/* File: src/pin_ctl_pkg.sv */
package pin_ctl_pkg;

  typedef struct packed {
    logic fault_b;
    logic fault_a;
    logic irq_b;
    logic irq_a;
  } evt_t;

  typedef struct packed {
    logic conv_en;
    logic irq_b_en;
    logic irq_a_en;
    logic pol_b;
    logic pol_a;
  } irq_cfg_t;

  typedef enum logic {
    BOOT_SAMPLE,
    BOOT_RUN
  } boot_state_t;

endpackage : pin_ctl_pkg

/* File: src/pin_irq_cpu_clock_out_pin_boot_ctl.sv */
// Function
// - Both user interrupt pins are edge detected with a software-chosen polarity.
// - The second interrupt pin also starts the converter, or is a plain GPIO.
// - The clock pin carries the CPU clock or the watchdog clock by bit 14, else GPIO.
// - The second power fault input raises its interrupt on a falling edge.
// - A second power fault puts all PWM pins of the second event manager in high-Z.
// - The boot pin is sampled as an input at reset into bit 3 of the second status reg.
// - After reset the boot pin drives the external flag output, high.
// - Parts without boot memory ignore the sampled boot value.
// - Every GPIO pin except the clock pin (bit 2, driven by the clock enable) comes up as an input after reset.
// - The crystal output goes high-Z while the emulation off input is low.
// - The first power fault input is falling-edge and puts the first PWM pins in high-Z.
`timescale 1ns/1ps
`include "pin_ctl_params.svh"
module pin_irq_cpu_clock_out_pin_boot_ctl
  import pin_ctl_pkg::*;
#(
  parameter bit HAS_BOOT_ROM = 1'b1
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // AXI4-Lite slave
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Interrupt and fault pins
  input  wire logic               user_irq_in_a,
  input  wire logic               user_irq_in_b,
  input  wire logic               power_fault_in_first,
  input  wire logic               power_fault_in_second,
  // Clocks and oscillator
  input  wire logic               watchdog_tick_clock,
  input  wire logic               emulation_off_ctl_n,
  input  wire logic               osc_drive_in,
  output logic                    crystal_out_pin,
  output logic                    crystal_out_oe,
  // GPIO pads: a2, d0, e0 (clock out), f6
  input  wire logic               gpio_port_e_bit0_in,
  input  wire logic               gpio_port_f_bit6_in,
  output logic [`GPIO_N-1:0]      gpio_out,
  output logic [`GPIO_N-1:0]      gpio_oe,
  // Boot strap and flag pin
  input  wire logic               boot_flag_in,
  output logic                    external_flag_out,
  output logic                    external_flag_oe,
  output logic                    boot_rom_sel,
  // PWM enables of both event managers
  input  wire logic [`PWM_W-1:0]  pwm_first_oe_req,
  input  wire logic [`PWM_W-1:0]  pwm_second_oe_req,
  output logic [`PWM_W-1:0]       pwm_first_oe,
  output logic [`PWM_W-1:0]       pwm_second_oe,
  // Converter trigger and interrupt
  output logic                    conv_start_trigger_req,
  output logic                    irq
);

  logic [`SYNC_N-1:0] pin_raw;
  logic [`SYNC_N-1:0] pin_lvl;
  logic [`SYNC_N-1:0] pin_rise;
  logic [`SYNC_N-1:0] pin_fall;
  logic               boot_en;

  assign pin_raw = {gpio_port_f_bit6_in, gpio_port_e_bit0_in, boot_flag_in,
                    emulation_off_ctl_n, power_fault_in_second,
                    power_fault_in_first, user_irq_in_b, user_irq_in_a};

  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_N; gi++)
    begin : g_sync
      pin_sync_edge u_sync (
        .mclk  (mclk),
        .reset (reset),
        .pin   (pin_raw[gi]),
        .lvl   (pin_lvl[gi]),
        .rise  (pin_rise[gi]),
        .fall  (pin_fall[gi])
      );
    end
  endgenerate

  // Bus state.
  logic        aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [7:0]  waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        do_wr;

  // Register state.
  logic                clk_sel_ff, nxt_clk_sel, clk_en_ff, nxt_clk_en;
  logic                flag_lvl_ff, nxt_flag_lvl;
  irq_cfg_t            cfg_ff, nxt_cfg;
  logic [`GPIO_N-1:0]  dir_ff, nxt_dir, dout_ff, nxt_dout;
  evt_t                stat_ff, nxt_stat, mask_ff, nxt_mask, evt, clr;
  logic                edge_b;

  // Pin state.
  logic [`GPIO_N-1:0]  gout_ff, nxt_gout, goe_ff, nxt_goe;
  logic [`PWM_W-1:0]   pwm1_ff, nxt_pwm1, pwm2_ff, nxt_pwm2;
  logic                xo_ff, nxt_xo, xoe_ff, nxt_xoe;
  logic                conv_ff, nxt_conv, irq_ff, nxt_irq;

  assign do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;

  // Address and data are taken in either order; once both are held, the write
  // lands and the response is raised on the same edge.
  always_comb
  begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (awvalid && awready_ff)
    begin
      nxt_aw_held = 1'b1;
      nxt_waddr   = awaddr;
    end
    if (wvalid && wready_ff)
    begin
      nxt_w_held = 1'b1;
      nxt_wdata  = wdata;
      nxt_wstrb  = wstrb;
    end
    if (bvalid_ff && bready)
      nxt_bvalid = 1'b0;
    if (do_wr)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (waddr_ff > `ADDR_IRQ_MASK || waddr_ff[1:0] != 2'h0) ?
                    `RESP_SLVERR : `RESP_OKAY;
    end
    if (rvalid_ff && rready)
      nxt_rvalid = 1'b0;
    if (arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `RESP_OKAY;
      nxt_rdata  = 32'h0;
      case (araddr)
        `ADDR_SYSCTL:
        begin
          nxt_rdata[`CLK_SEL_BIT] = clk_sel_ff;
          nxt_rdata[`CLK_EN_BIT]  = clk_en_ff;
        end
        `ADDR_SYSCTL2:
        begin
          nxt_rdata[`BOOT_EN_BIT] = boot_en;
          nxt_rdata[`FLAG_BIT]    = flag_lvl_ff;
        end
        `ADDR_IRQ_CFG:  nxt_rdata[4:0] = cfg_ff;
        `ADDR_GPIO_DIR: nxt_rdata[3:0] = dir_ff;
        `ADDR_GPIO_OUT: nxt_rdata[3:0] = dout_ff;
        `ADDR_GPIO_IN:  nxt_rdata[3:0] = {pin_lvl[`SY_F6], pin_lvl[`SY_E0],
                                          pin_lvl[`SY_IRQB], pin_lvl[`SY_IRQA]};
        `ADDR_IRQ_STAT: nxt_rdata[3:0] = stat_ff;
        `ADDR_IRQ_MASK: nxt_rdata[3:0] = mask_ff;
        default:        nxt_rresp      = `RESP_SLVERR;
      endcase
    end
    nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
    nxt_wready  = ~nxt_w_held & ~nxt_bvalid;
    nxt_arready = ~nxt_rvalid;
  end

  always_comb
  begin
    nxt_clk_sel = clk_sel_ff;
    nxt_clk_en  = clk_en_ff;
    nxt_flag_lvl = flag_lvl_ff;
    nxt_cfg     = cfg_ff;
    nxt_dir     = dir_ff;
    nxt_dout    = dout_ff;
    nxt_mask    = mask_ff;
    clr         = '0;
    if (do_wr)
    begin
      case (waddr_ff)
        `ADDR_SYSCTL:
        begin
          if (wstrb_ff[1])
            nxt_clk_sel = wdata_ff[`CLK_SEL_BIT];
          if (wstrb_ff[0])
            nxt_clk_en = wdata_ff[`CLK_EN_BIT];
        end
        `ADDR_SYSCTL2:
          if (wstrb_ff[0])
            nxt_flag_lvl = wdata_ff[`FLAG_BIT];
        `ADDR_IRQ_CFG:
          if (wstrb_ff[0])
            nxt_cfg = wdata_ff[4:0];
        `ADDR_GPIO_DIR:
          if (wstrb_ff[0])
            nxt_dir = wdata_ff[3:0];
        `ADDR_GPIO_OUT:
          if (wstrb_ff[0])
            nxt_dout = wdata_ff[3:0];
        `ADDR_IRQ_STAT:
          if (wstrb_ff[0])
            clr = wdata_ff[3:0];
        `ADDR_IRQ_MASK:
          if (wstrb_ff[0])
            nxt_mask = wdata_ff[3:0];
        default:
          nxt_mask = mask_ff;
      endcase
    end
    evt.irq_a = cfg_ff.irq_a_en &
                (cfg_ff.pol_a ? pin_rise[`SY_IRQA] : pin_fall[`SY_IRQA]);
    edge_b    = cfg_ff.pol_b ? pin_rise[`SY_IRQB] : pin_fall[`SY_IRQB];
    evt.irq_b = cfg_ff.irq_b_en & edge_b;
    evt.fault_a = pin_fall[`SY_FLTA];
    evt.fault_b = pin_fall[`SY_FLTB];
    nxt_stat = (stat_ff & ~clr) | evt;
    nxt_irq  = |(nxt_stat & nxt_mask);
  end

  // Pin drivers. The clock image toggles its own flop, so the pin shows the
  // CPU clock at half rate; a full-rate copy cannot come from a flop.
  always_comb
  begin
    nxt_conv = cfg_ff.conv_en & edge_b;
    nxt_goe[0] = dir_ff[0] & ~cfg_ff.irq_a_en;
    nxt_goe[1] = dir_ff[1] & ~cfg_ff.irq_b_en & ~cfg_ff.conv_en;
    nxt_goe[2] = clk_en_ff | dir_ff[2];
    nxt_goe[3] = dir_ff[3];
    nxt_gout   = dout_ff;
    if (clk_en_ff)
      nxt_gout[2] = clk_sel_ff ? watchdog_tick_clock : ~gout_ff[2];
    nxt_pwm2 = pwm_second_oe_req & {`PWM_W{~nxt_stat.fault_b}};
    nxt_pwm1 = pwm_first_oe_req & {`PWM_W{~nxt_stat.fault_a}};
    nxt_xo   = osc_drive_in;
    nxt_xoe  = pin_lvl[`SY_EMU];
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= `RESP_OKAY;
      clk_sel_ff <= `RST_CLK_SEL;
      clk_en_ff  <= `RST_CLK_EN;
      flag_lvl_ff <= `RST_FLAG;
      cfg_ff     <= '0;
      dir_ff     <= '0;
      dout_ff    <= '0;
      stat_ff    <= '0;
      mask_ff    <= '0;
      gout_ff    <= '0;
      goe_ff     <= '0;
      pwm1_ff    <= '0;
      pwm2_ff    <= '0;
      xo_ff      <= 1'b0;
      xoe_ff     <= 1'b0;
      conv_ff    <= 1'b0;
      irq_ff     <= 1'b0;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      clk_sel_ff <= nxt_clk_sel;
      clk_en_ff  <= nxt_clk_en;
      flag_lvl_ff <= nxt_flag_lvl;
      cfg_ff     <= nxt_cfg;
      dir_ff     <= nxt_dir;
      dout_ff    <= nxt_dout;
      stat_ff    <= nxt_stat;
      mask_ff    <= nxt_mask;
      gout_ff    <= nxt_gout;
      goe_ff     <= nxt_goe;
      pwm1_ff    <= nxt_pwm1;
      pwm2_ff    <= nxt_pwm2;
      xo_ff      <= nxt_xo;
      xoe_ff     <= nxt_xoe;
      conv_ff    <= nxt_conv;
      irq_ff     <= nxt_irq;
    end
  end

  pin_boot_strap #(
    .HAS_BOOT_ROM (HAS_BOOT_ROM)
  ) u_boot (
    .mclk         (mclk),
    .reset        (reset),
    .strap_lvl    (pin_lvl[`SY_BOOT]),
    .flag_level   (flag_lvl_ff),
    .boot_en      (boot_en),
    .boot_rom_sel (boot_rom_sel),
    .flag_out     (external_flag_out),
    .flag_oe      (external_flag_oe)
  );

  assign awready                = awready_ff;
  assign wready                 = wready_ff;
  assign bvalid                 = bvalid_ff;
  assign bresp                  = bresp_ff;
  assign arready                = arready_ff;
  assign rvalid                 = rvalid_ff;
  assign rdata                  = rdata_ff;
  assign rresp                  = rresp_ff;
  assign gpio_out               = gout_ff;
  assign gpio_oe                = goe_ff;
  assign pwm_first_oe           = pwm1_ff;
  assign pwm_second_oe          = pwm2_ff;
  assign crystal_out_pin        = xo_ff;
  assign crystal_out_oe         = xoe_ff;
  assign conv_start_trigger_req = conv_ff;
  assign irq                    = irq_ff;

  AST_IRQ_A_EDGE: assert property (@(posedge mclk) disable iff (reset)
    evt.irq_a |=> stat_ff.irq_a ##0 (irq == mask_ff.irq_a || stat_ff != 4'h1 || irq))
    else $error("Edge on interrupt pin a not flagged.");

  AST_CONV_TRIG: assert property (@(posedge mclk) disable iff (reset)
    (cfg_ff.conv_en && edge_b) |=> conv_start_trigger_req ##1 !conv_start_trigger_req)
    else $error("Converter trigger not a single pulse after the edge.");

  AST_CLK_WD: assert property (@(posedge mclk) disable iff (reset)
    (clk_en_ff && clk_sel_ff) |=> gpio_out[2] == $past(watchdog_tick_clock) && gpio_oe[2])
    else $error("Clock pin does not follow the watchdog clock.");

  AST_FAULT_B_FALL: assert property (@(posedge mclk) disable iff (reset)
    pin_fall[`SY_FLTB] |=> stat_ff.fault_b)
    else $error("Falling edge of second fault input not flagged.");

  AST_PWM_B_HIZ: assert property (@(posedge mclk) disable iff (reset)
    stat_ff.fault_b |-> pwm_second_oe == '0)
    else $error("Second PWM group driven during a fault.");

  AST_GPIO_DIR_IN: assert property (@(posedge mclk) disable iff (reset)
    (dir_ff[3] == 1'b0) |=> !gpio_oe[3])
    else $error("GPIO driven while set as input.");

  AST_XTAL_HIZ: assert property (@(posedge mclk) disable iff (reset)
    !pin_lvl[`SY_EMU] |=> !crystal_out_oe)
    else $error("Crystal output driven while emulation off is low.");

  AST_PWM_A_HIZ: assert property (@(posedge mclk) disable iff (reset)
    stat_ff.fault_a |-> pwm_first_oe == '0)
    else $error("First PWM group driven during a fault.");

  AST_ONE_PER_EDGE: assert property (@(posedge mclk) disable iff (reset)
    pin_fall[`SY_FLTA] |=> !pin_fall[`SY_FLTA])
    else $error("One edge produced two requests.");

  AST_HIZ_HOLD: assert property (@(posedge mclk) disable iff (reset)
    (stat_ff.fault_b && !clr.fault_b) |=> stat_ff.fault_b)
    else $error("Fault flag dropped without a software clear.");

  COV_IRQ_B: cover property (@(posedge mclk) disable iff (reset) evt.irq_b ##1 irq);
  COV_FAULT_CLR: cover property (@(posedge mclk) disable iff (reset)
    stat_ff.fault_a ##1 !stat_ff.fault_a);
  COV_WR_RD: cover property (@(posedge mclk) disable iff (reset) bvalid ##[1:4] rvalid);

endmodule : pin_irq_cpu_clock_out_pin_boot_ctl

/* File: src/pin_sync_edge.sv */
`timescale 1ns/1ps
`include "pin_ctl_params.svh"
module pin_sync_edge (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Pin and results
  input  wire logic pin,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic nxt_lvl;

  // The level moves only once the second and third stages agree.
  always_comb
  begin
    nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s1_ff  <= `RST_SYNC;
      s2_ff  <= `RST_SYNC;
      s3_ff  <= `RST_SYNC;
      lvl_ff <= `RST_SYNC;
    end
    else
    begin
      s1_ff  <= pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign lvl  = lvl_ff;
  assign rise = nxt_lvl & ~lvl_ff;
  assign fall = ~nxt_lvl & lvl_ff;

endmodule : pin_sync_edge

/* File: tb/pin_board_model.sv */
`timescale 1ns/1ps
module pin_board_model (
  // Bench commands
  input  wire logic [1:0] fault_cmd,
  input  wire logic       strap_hi,
  // Flag pad drive
  input  wire logic       flag_out,
  input  wire logic       flag_oe,
  // Pad levels
  output logic            fault_first_n,
  output logic            fault_second_n,
  output logic            boot_pad
);
  // Fault lines idle high on pull-ups.
  assign fault_first_n  = ~fault_cmd[0];
  assign fault_second_n = ~fault_cmd[1];
  // The strap is passive, so the flag drive overrides it.
  assign boot_pad = flag_oe ? flag_out : strap_hi;
endmodule : pin_board_model

/* File: tb/tb_pin_irq_cpu_clock_out_pin_boot_ctl.sv */
`timescale 1ns/1ps
`include "pin_ctl_params.svh"
module tb_pin_irq_cpu_clock_out_pin_boot_ctl
  import pin_ctl_pkg::*;
;
  logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, user_irq_in_a, user_irq_in_b, irq, strap;
  logic        crystal_out_pin, crystal_out_oe, external_flag_out, external_flag_oe;
  logic        boot_rom_sel, conv_start_trigger_req, emulation_off_ctl_n, flt1, flt2;
  logic        boot_flag_in, wd, wd_d;
  logic [1:0]  bresp, rresp, fault_cmd, gin;
  logic [1:0]  bq[$];
  logic [3:0]  wstrb, gpio_out, gpio_oe;
  logic [7:0]  awaddr, araddr, pwm_first_oe_req, pwm_second_oe_req;
  logic [7:0]  pwm_first_oe, pwm_second_oe;
  logic [15:0] m;
  logic [31:0] wdata, rdata;
  logic [33:0] expq[$];
  int          errors, checks_done, convs;

  pin_irq_cpu_clock_out_pin_boot_ctl uut (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .user_irq_in_a, .user_irq_in_b, .power_fault_in_first(flt1),
    .power_fault_in_second(flt2), .watchdog_tick_clock(wd), .emulation_off_ctl_n,
    .osc_drive_in(wd), .crystal_out_pin, .crystal_out_oe, .gpio_port_e_bit0_in(gin[0]),
    .gpio_port_f_bit6_in(gin[1]), .gpio_out, .gpio_oe, .boot_flag_in, .external_flag_out,
    .external_flag_oe, .boot_rom_sel, .pwm_first_oe_req, .pwm_second_oe_req, .pwm_first_oe,
    .pwm_second_oe, .conv_start_trigger_req, .irq);

  pin_board_model board (.fault_cmd, .strap_hi(strap), .flag_out(external_flag_out),
    .flag_oe(external_flag_oe), .fault_first_n(flt1), .fault_second_n(flt2),
    .boot_pad(boot_flag_in));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  // Ready and valid are read before the edge's own updates land.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    bq.push_back((a > `ADDR_IRQ_MASK) ? `RESP_SLVERR : `RESP_OKAY);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 50);
    if (n >= 50)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    expq.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 50);
    if (n >= 50)
    begin
      errors++;
      report_and_stop();
    end
  endtask : rd

  task automatic pins(input logic a, input logic b);
    user_irq_in_a <= a;
    user_irq_in_b <= b;
    wt(8);
  endtask : pins

  task automatic do_reset;
    reset <= 1'b1;
    wt(8);
    reset <= 1'b0;
    wt(10);
  endtask : do_reset

  always @(posedge mclk)
  begin
    if (rvalid && rready)
      chk({rresp, rdata}, expq.pop_front());
    if (bvalid && bready)
      chk(bresp, bq.pop_front());
    if (conv_start_trigger_req)
      convs++;
  end

  // Watchdog clock and oscillator drive; wd_d is the value the design registered.
  always @(posedge mclk)
  begin
    wd   <= 1'($urandom);
    wd_d <= wd;
  end

  initial
  begin
    reset <= 1'b1;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, fault_cmd} <= '0;
    {bready, rready, user_irq_in_a, user_irq_in_b, emulation_off_ctl_n} <= 5'h1f;
    wstrb <= 4'hf;
    errors = 0;
    checks_done = 0;
    convs = 0;
    void'($urandom(32'hcbdd));
    {strap, pwm_first_oe_req, pwm_second_oe_req} <= 17'($urandom);
    gin <= 2'($urandom);
    do_reset();
    chk(gpio_oe & 4'hb, 0);
    chk({external_flag_oe, external_flag_out, boot_rom_sel}, {2'b11, strap});
    rd(`ADDR_SYSCTL, 34'h1);
    m[0] = gpio_out[2];
    wt(1);
    chk(gpio_out[2], !m[0]);
    rd(`ADDR_SYSCTL2, {30'h0, strap, 3'h1});
    wr(`ADDR_SYSCTL, 32'h4001);
    rd(`ADDR_SYSCTL, 34'h4001);
    chk(gpio_out[2], wd_d);
    chk(crystal_out_pin, wd_d);
    rd(8'h20, {2'b10, 32'h0});
    wr(8'h20, 32'h0);
    rd(`ADDR_GPIO_IN, {30'h0, gin, 2'h3});
    wr(`ADDR_IRQ_CFG, 32'hf);
    wr(`ADDR_IRQ_MASK, 32'h3);
    wr(`ADDR_IRQ_STAT, 32'hf);
    pins(0, 0);
    rd(`ADDR_IRQ_STAT, 34'h0);
    pins(1, 1);
    rd(`ADDR_IRQ_STAT, 34'h3);
    chk(irq, 1);
    wr(`ADDR_IRQ_CFG, 32'h10);
    convs = 0;
    pins(1, 0);
    pins(1, 1);
    chk(convs, 1);
    wr(`ADDR_IRQ_STAT, 32'hf);
    wr(`ADDR_IRQ_MASK, 32'hc);
    for (int i = 0; i < 2; i++)
    begin
      m = 16'hff << (8 * i);
      fault_cmd[i] <= 1'b1;
      wt(8);
      chk({pwm_second_oe, pwm_first_oe}, {pwm_second_oe_req, pwm_first_oe_req} & ~m);
      chk(irq, 1);
      fault_cmd[i] <= 1'b0;
      wt(8);
      rd(`ADDR_IRQ_STAT, 34'(4 << i));
      chk({pwm_second_oe, pwm_first_oe}, {pwm_second_oe_req, pwm_first_oe_req} & ~m);
      wr(`ADDR_IRQ_STAT, 32'(4 << i));
      wt(4);
      chk({pwm_second_oe, pwm_first_oe, irq}, {pwm_second_oe_req, pwm_first_oe_req, 1'b0});
    end
    emulation_off_ctl_n <= 1'b0;
    wt(6);
    chk(crystal_out_oe, 0);
    emulation_off_ctl_n <= 1'b1;
    wt(6);
    chk(crystal_out_oe, 1);
    wr(`ADDR_IRQ_CFG, 32'h0);
    wr(`ADDR_GPIO_DIR, 32'hf);
    wr(`ADDR_GPIO_OUT, 32'h5);
    wt(2);
    chk(gpio_oe & 4'hb, 4'hb);
    chk(gpio_out & 4'hb, 4'h1);
    wr(`ADDR_SYSCTL, 32'h0);
    wr(`ADDR_SYSCTL2, 32'h0);
    wt(2);
    chk({gpio_out, external_flag_out}, {4'h5, 1'b0});
    // A second reset in mid-run must return GPIO pins 0, 1 and 3 to inputs and drive the flag high again.
    do_reset();
    chk(gpio_oe & 4'hb, 0);
    rd(`ADDR_SYSCTL, 34'h1);
    chk(external_flag_out, 1);
    report_and_stop();
  end
endmodule : tb_pin_irq_cpu_clock_out_pin_boot_ctl
